//--- rtl/ddrcap_top.sv
// Command, address and clock-enable logic of a DDR3 memory device, eight banks, 16-bit data.
// Assumes the pads deliver rise and fall data beats as pairs on the memory clock, and an
// array beside the link returns i_rd_word for the address on o_arr_* in the same cycle.
`timescale 1ns/1ns
module ddrcap_top #(
    parameter int CAS_LAT = ddrcap_pkg::CAS_LAT_DEF,
    parameter int CWL = ddrcap_pkg::CWL_DEF,
    parameter int FIFO_DEPTH = ddrcap_pkg::FIFO_DEPTH_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_cfg_bl8,
    input wire logic i_cfg_interleave,
    input wire logic [1:0] i_cfg_al,
    input wire logic i_wr_ready,
    output logic o_wr_valid,
    output logic [ddrcap_pkg::BA_W-1:0] o_wr_bank,
    output logic [ddrcap_pkg::ROW_W-1:0] o_wr_row,
    output logic [ddrcap_pkg::COL_W-1:0] o_wr_col,
    output logic [2*ddrcap_pkg::DQ_W-1:0] o_wr_data,
    output logic [2*ddrcap_pkg::DM_W-1:0] o_wr_be,
    output logic o_powerdown,
    output logic o_self_refresh,
    output logic o_overflow,
    output logic [ddrcap_pkg::BANKS-1:0] o_bank_open,
    input wire logic i_mem_ck,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [ddrcap_pkg::BA_W-1:0] i_ba,
    input wire logic [ddrcap_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ddrcap_pkg::DQ_W-1:0] i_dq_rise,
    input wire logic [ddrcap_pkg::DQ_W-1:0] i_dq_fall,
    input wire logic [ddrcap_pkg::DM_W-1:0] i_dm_rise,
    input wire logic [ddrcap_pkg::DM_W-1:0] i_dm_fall,
    input wire logic [2*ddrcap_pkg::DQ_W-1:0] i_rd_word,
    output logic [ddrcap_pkg::DQ_W-1:0] o_dq_rise,
    output logic [ddrcap_pkg::DQ_W-1:0] o_dq_fall,
    output logic o_dq_oe,
    output logic o_arr_rd,
    output logic [ddrcap_pkg::BA_W-1:0] o_arr_bank,
    output logic [ddrcap_pkg::ROW_W-1:0] o_arr_row,
    output logic [ddrcap_pkg::COL_W-1:0] o_arr_col
);
    localparam int STAT_W = ddrcap_pkg::BANKS + 3;

    logic lrst_s1_q, lrst_q;
    logic [3:0] cfg_s1_q, cfg_q;
    ddrcap_fifo_if #(.W(ddrcap_pkg::REC_W)) fifo_if ();

    ddrcap_fifo #(.W(ddrcap_pkg::REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_wclk(i_mem_ck),
        .i_wrst(lrst_q),
        .i_rclk(i_core_clk),
        .i_rrst(i_reset),
        .port(fifo_if.store)
    );

    // Link-domain reset and configuration arrive from the core clock through two flops each.
    always_ff @(posedge i_mem_ck) begin
        lrst_s1_q <= i_reset;
        lrst_q <= lrst_s1_q;
        cfg_s1_q <= {i_cfg_al, i_cfg_interleave, i_cfg_bl8};
        cfg_q <= cfg_s1_q;
    end

    logic cfg_bl8, cfg_il;
    logic [1:0] cfg_al;
    assign cfg_bl8 = cfg_q[0];
    assign cfg_il = cfg_q[1];
    assign cfg_al = cfg_q[3:2];

    // Column of a beat pair within the burst; a chopped burst wraps inside four columns.
    function automatic logic [ddrcap_pkg::COL_W-1:0] f_col(input logic [ddrcap_pkg::COL_W-1:0] base,
                                                           input logic [1:0] pair,
                                                           input logic il,
                                                           input logic full8);
        logic [2:0] beat;
        logic [2:0] low;
        beat = {pair, 1'b0};
        low = il ? (base[2:0] ^ beat) : (base[2:0] + beat);
        if (!full8) begin
            low[2] = base[2];
        end
        return {base[ddrcap_pkg::COL_W-1:3], low};
    endfunction : f_col

    ddrcap_pkg::ddrcap_state_t st_q, st_d;
    logic [ddrcap_pkg::BANKS-1:0] open_q, open_d;
    logic [ddrcap_pkg::ROW_W-1:0] rows_q [ddrcap_pkg::BANKS];
    logic [ddrcap_pkg::ROW_W-1:0] rows_d [ddrcap_pkg::BANKS];
    logic [ddrcap_pkg::BA_W-1:0] bank_q, bank_d;
    logic [ddrcap_pkg::ROW_W-1:0] row_q, row_d;
    logic [ddrcap_pkg::COL_W-1:0] col_q, col_d, arr_col_q, arr_col_d;
    logic [2:0] pairs_q, pairs_d;
    logic [1:0] idx_q, idx_d;
    logic [ddrcap_pkg::LAT_W-1:0] lat_q, lat_d, al_v, tot_v;
    logic wr_q, wr_d, ap_q, ap_d, full8_q, full8_d;
    logic cke_q, pd_q, pd_d, sr_q, sr_d, ovf_q, ovf_d;
    logic arr_rd_q, arr_rd_d, dq_oe_q, dq_oe_d;
    logic [ddrcap_pkg::DQ_W-1:0] dq_r_q, dq_r_d, dq_f_q, dq_f_d;
    logic cmd_ok, adv, last;
    logic [2:0] cmd;
    ddrcap_pkg::ddrcap_rec_t rec;

    assign cmd = {i_ras_n, i_cas_n, i_we_n};
    assign cmd_ok = i_cke && cke_q && !i_cs_n;
    assign fifo_if.push_data = rec;

    always_comb begin
        st_d = st_q;
        open_d = open_q;
        rows_d = rows_q;
        bank_d = bank_q;
        row_d = row_q;
        col_d = col_q;
        wr_d = wr_q;
        ap_d = ap_q;
        full8_d = full8_q;
        pairs_d = pairs_q;
        idx_d = idx_q;
        lat_d = lat_q;
        pd_d = pd_q;
        sr_d = sr_q;
        ovf_d = ovf_q;
        arr_rd_d = arr_rd_q;
        arr_col_d = arr_col_q;
        dq_r_d = dq_r_q;
        dq_f_d = dq_f_q;
        dq_oe_d = dq_oe_q;
        adv = 1'b0;
        last = ({1'b0, idx_q} == pairs_q - 3'h1);
        fifo_if.push_valid = 1'b0;
        rec.bank = bank_q;
        rec.row = row_q;
        rec.col = f_col(col_q, idx_q, cfg_il, full8_q);
        rec.data = {i_dq_fall, i_dq_rise};
        rec.be = ~{i_dm_fall, i_dm_rise};
        unique case (cfg_al)
            ddrcap_pkg::AL_CL1: al_v = ddrcap_pkg::LAT_W'(CAS_LAT - 1);
            ddrcap_pkg::AL_CL2: al_v = ddrcap_pkg::LAT_W'(CAS_LAT - 2);
            default: al_v = '0;
        endcase
        tot_v = al_v + ((cmd == ddrcap_pkg::CMD_WR) ? ddrcap_pkg::LAT_W'(CWL) : ddrcap_pkg::LAT_W'(CAS_LAT));
        // Everything below except the power-down and self-refresh exit advances only while the internal clock runs.
        if (cke_q) begin
            dq_oe_d = arr_rd_q;
            if (arr_rd_q) begin
                dq_r_d = i_rd_word[ddrcap_pkg::DQ_W-1:0];
                dq_f_d = i_rd_word[2*ddrcap_pkg::DQ_W-1:ddrcap_pkg::DQ_W];
            end
            arr_rd_d = 1'b0;
            unique case (st_q)
                ddrcap_pkg::ST_IDLE: begin
                    if (cmd_ok && (cmd == ddrcap_pkg::CMD_RD || cmd == ddrcap_pkg::CMD_WR) && open_q[i_ba]) begin
                        bank_d = i_ba;
                        row_d = rows_q[i_ba];
                        col_d = i_addr[ddrcap_pkg::COL_W-1:0];
                        ap_d = i_addr[ddrcap_pkg::AP_BIT];
                        wr_d = (cmd == ddrcap_pkg::CMD_WR);
                        full8_d = cfg_bl8 && i_addr[ddrcap_pkg::BC_BIT];
                        pairs_d = full8_d ? ddrcap_pkg::PAIRS_BL8 : ddrcap_pkg::PAIRS_BC4;
                        lat_d = tot_v - 1'b1;
                        st_d = ddrcap_pkg::ST_WAIT;
                    end
                end
                ddrcap_pkg::ST_WAIT: begin
                    if (lat_q == '0) begin
                        st_d = ddrcap_pkg::ST_DATA;
                        idx_d = 2'h0;
                        arr_rd_d = !wr_q;
                        arr_col_d = f_col(col_q, 2'h0, cfg_il, full8_q);
                    end else begin
                        lat_d = lat_q - 1'b1;
                    end
                end
                ddrcap_pkg::ST_DATA: begin
                    adv = 1'b1;
                    if (wr_q) begin
                        fifo_if.push_valid = 1'b1;
                        // A full FIFO stalls the burst at this pair and is flagged; the beat on the pins that cycle is lost.
                        if (!fifo_if.push_ready) begin
                            adv = 1'b0;
                            ovf_d = 1'b1;
                        end
                    end
                    if (!adv) begin
                        arr_rd_d = arr_rd_q;
                    end else if (last) begin
                        st_d = ddrcap_pkg::ST_IDLE;
                        if (ap_q) begin
                            open_d[bank_q] = 1'b0;
                        end
                    end else begin
                        idx_d = idx_q + 2'h1;
                        arr_rd_d = !wr_q;
                        arr_col_d = f_col(col_q, idx_d, cfg_il, full8_q);
                    end
                end
            endcase
        end
        if (cmd_ok && cmd == ddrcap_pkg::CMD_ACT) begin
            open_d[i_ba] = 1'b1;
            rows_d[i_ba] = i_addr[ddrcap_pkg::ROW_W-1:0];
        end
        if (cmd_ok && cmd == ddrcap_pkg::CMD_PRE) begin
            if (i_addr[ddrcap_pkg::AP_BIT]) begin
                open_d = '0;
            end else begin
                open_d[i_ba] = 1'b0;
            end
        end
        if (cke_q && !i_cke && open_q == '0 && st_q == ddrcap_pkg::ST_IDLE) begin
            if (!i_cs_n && cmd == ddrcap_pkg::CMD_REF) begin
                sr_d = 1'b1;
            end else begin
                pd_d = 1'b1;
            end
        end
        if (i_cke) begin
            pd_d = 1'b0;
            sr_d = 1'b0;
        end
    end

    always_ff @(posedge i_mem_ck) begin
        if (lrst_q) begin
            st_q <= ddrcap_pkg::ST_IDLE;
            open_q <= ddrcap_pkg::OPEN_RST;
            rows_q <= '{default: '0};
            bank_q <= '0;
            row_q <= '0;
            col_q <= '0;
            wr_q <= 1'b0;
            ap_q <= 1'b0;
            full8_q <= 1'b0;
            pairs_q <= ddrcap_pkg::PAIRS_BC4;
            idx_q <= '0;
            lat_q <= '0;
            cke_q <= 1'b0;
            pd_q <= 1'b0;
            sr_q <= 1'b0;
            ovf_q <= 1'b0;
            arr_rd_q <= 1'b0;
            arr_col_q <= '0;
            dq_r_q <= '0;
            dq_f_q <= '0;
            dq_oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            open_q <= open_d;
            rows_q <= rows_d;
            bank_q <= bank_d;
            row_q <= row_d;
            col_q <= col_d;
            wr_q <= wr_d;
            ap_q <= ap_d;
            full8_q <= full8_d;
            pairs_q <= pairs_d;
            idx_q <= idx_d;
            lat_q <= lat_d;
            cke_q <= i_cke;
            pd_q <= pd_d;
            sr_q <= sr_d;
            ovf_q <= ovf_d;
            arr_rd_q <= arr_rd_d;
            arr_col_q <= arr_col_d;
            dq_r_q <= dq_r_d;
            dq_f_q <= dq_f_d;
            dq_oe_q <= dq_oe_d;
        end
    end

    assign o_dq_rise = dq_r_q;
    assign o_dq_fall = dq_f_q;
    assign o_dq_oe = dq_oe_q;
    assign o_arr_rd = arr_rd_q;
    assign o_arr_bank = bank_q;
    assign o_arr_row = row_q;
    assign o_arr_col = arr_col_q;

    // Status bits change rarely, so each is carried as a level through two flops.
    logic [STAT_W-1:0] stat_s1_q, stat_s2_q;
    ddrcap_pkg::ddrcap_rec_t out_q, out_d;
    logic out_valid_q, out_valid_d;

    assign fifo_if.pop_ready = !out_valid_q || i_wr_ready;

    always_comb begin
        out_d = out_q;
        out_valid_d = out_valid_q;
        if (fifo_if.pop_ready) begin
            out_valid_d = fifo_if.pop_valid;
            if (fifo_if.pop_valid) begin
                out_d = fifo_if.pop_data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            stat_s1_q <= '0;
            stat_s2_q <= '0;
            out_q <= '0;
            out_valid_q <= 1'b0;
        end else begin
            stat_s1_q <= {ovf_q, sr_q, pd_q, open_q};
            stat_s2_q <= stat_s1_q;
            out_q <= out_d;
            out_valid_q <= out_valid_d;
        end
    end

    assign o_bank_open = stat_s2_q[ddrcap_pkg::BANKS-1:0];
    assign o_powerdown = stat_s2_q[ddrcap_pkg::BANKS];
    assign o_self_refresh = stat_s2_q[ddrcap_pkg::BANKS+1];
    assign o_overflow = stat_s2_q[ddrcap_pkg::BANKS+2];
    assign o_wr_valid = out_valid_q;
    assign o_wr_bank = out_q.bank;
    assign o_wr_row = out_q.row;
    assign o_wr_col = out_q.col;
    assign o_wr_data = out_q.data;
    assign o_wr_be = out_q.be;

    AST_ACT_OPEN: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        cmd_ok && cmd == ddrcap_pkg::CMD_ACT |=> open_q[$past(i_ba)] && rows_q[$past(i_ba)] == $past(i_addr))
        else $error("Activate did not open the row.");
    AST_PRE_ONE: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        cmd_ok && cmd == ddrcap_pkg::CMD_PRE && !i_addr[ddrcap_pkg::AP_BIT] |=> !open_q[$past(i_ba)])
        else $error("Single precharge left the bank open.");
    AST_PRE_ALL: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        cmd_ok && cmd == ddrcap_pkg::CMD_PRE && i_addr[ddrcap_pkg::AP_BIT] |=> open_q == '0)
        else $error("Precharge all left a bank open.");
    AST_CS_IGNORE: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        i_cs_n && st_q == ddrcap_pkg::ST_IDLE |=> st_q == ddrcap_pkg::ST_IDLE && $stable(open_q))
        else $error("Command taken with chip select high.");
    AST_FREEZE: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        !cke_q |=> $stable(st_q) && $stable(idx_q) && $stable(dq_r_q) && $stable(arr_col_q))
        else $error("State moved while the clock was suspended.");
    AST_COL_AP: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        st_q == ddrcap_pkg::ST_IDLE && cke_q && cmd_ok && cmd == ddrcap_pkg::CMD_RD && open_q[i_ba]
        |=> col_q == $past(i_addr[ddrcap_pkg::COL_W-1:0]) && ap_q == $past(i_addr[ddrcap_pkg::AP_BIT]))
        else $error("Column or auto-precharge not latched.");
    AST_CHOP: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        st_q == ddrcap_pkg::ST_IDLE && cke_q && cmd_ok && cmd == ddrcap_pkg::CMD_WR && open_q[i_ba]
        |=> pairs_q == (($past(cfg_bl8) && $past(i_addr[ddrcap_pkg::BC_BIT])) ? 3'h4 : 3'h2))
        else $error("Burst length wrong.");
    AST_AP_CLOSE: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        cke_q && st_q == ddrcap_pkg::ST_DATA && adv && last && ap_q && !(cmd_ok && cmd == ddrcap_pkg::CMD_ACT)
        |=> !open_q[$past(bank_q)] && st_q == ddrcap_pkg::ST_IDLE)
        else $error("Auto-precharge did not close the bank.");
    AST_DDR: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        cke_q && arr_rd_q |=> dq_oe_q && dq_r_q == $past(i_rd_word[15:0]) && dq_f_q == $past(i_rd_word[31:16]))
        else $error("Read beats not driven.");
    AST_PD: assert property (@(posedge i_mem_ck) disable iff (lrst_q)
        cke_q && !i_cke && open_q == '0 && st_q == ddrcap_pkg::ST_IDLE |=> pd_q || sr_q)
        else $error("Power-down not entered.");
endmodule : ddrcap_top

//--- rtl/ddrcap_pkg.sv
// Constants, types and command codes for the DDR3 command and address port.
// Assumes nothing of its surroundings; ddrcap_top refers to it by scope, the FIFO and its interface do not use it.
package ddrcap_pkg;
    localparam int BANKS = 8;
    localparam int BA_W = 3;
    localparam int ADDR_W = 13;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int DQ_W = 16;
    localparam int DM_W = 2;
    localparam int LAT_W = 6;
    localparam int CAS_LAT_DEF = 5;
    localparam int CWL_DEF = 5;
    localparam int FIFO_DEPTH_DEF = 4;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [1:0] AL_CL1 = 2'h1;
    localparam logic [1:0] AL_CL2 = 2'h2;
    localparam logic [2:0] PAIRS_BL8 = 3'h4;
    localparam logic [2:0] PAIRS_BC4 = 3'h2;
    localparam logic [BANKS-1:0] OPEN_RST = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DATA} ddrcap_state_t;

    typedef struct packed {
        logic [BA_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [2*DQ_W-1:0] data;
        logic [2*DM_W-1:0] be;
    } ddrcap_rec_t;

    localparam int REC_W = $bits(ddrcap_rec_t);
endpackage : ddrcap_pkg

//--- rtl/ddrcap_fifo_if.sv
// Push and pop signals of the write-record FIFO between the link and core domains.
// Assumes the producer runs on the link clock and the consumer on the core clock.
`timescale 1ns/1ns
interface ddrcap_fifo_if #(parameter int W = 8) ();
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport producer(output push_valid, output push_data, input push_ready);
    modport store(input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
    modport consumer(input pop_valid, input pop_data, output pop_ready);
endinterface : ddrcap_fifo_if

//--- rtl/ddrcap_fifo.sv
// Dual-clock FIFO with gray-coded pointers, for the write records of the port.
// Assumes DEPTH is a power of two, at least four, and each reset is synchronous to its own clock.
`timescale 1ns/1ns
module ddrcap_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_wclk,
    input wire logic i_wrst,
    input wire logic i_rclk,
    input wire logic i_rrst,
    ddrcap_fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wbin_q, wbin_d, wgray_q, wgray_d;
    logic [AW:0] rbin_q, rbin_d, rgray_q, rgray_d;
    logic [AW:0] rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
    logic full, empty, do_push, do_pop;

    // Full compares against the read pointer after two flops in the write domain.
    always_comb begin
        full = (wgray_q == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
        do_push = port.push_valid && !full;
        wbin_d = do_push ? wbin_q + 1'b1 : wbin_q;
        wgray_d = wbin_d ^ (wbin_d >> 1);
        empty = (rgray_q == wg_s2_q);
        do_pop = port.pop_ready && !empty;
        rbin_d = do_pop ? rbin_q + 1'b1 : rbin_q;
        rgray_d = rbin_d ^ (rbin_d >> 1);
    end

    assign port.push_ready = !full;
    assign port.pop_valid = !empty;
    assign port.pop_data = mem_q[rbin_q[AW-1:0]];

    always_ff @(posedge i_wclk) begin
        if (i_wrst) begin
            wbin_q <= '0;
            wgray_q <= '0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            wbin_q <= wbin_d;
            wgray_q <= wgray_d;
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
        end
        if (do_push) begin
            mem_q[wbin_q[AW-1:0]] <= port.push_data;
        end
    end

    always_ff @(posedge i_rclk) begin
        if (i_rrst) begin
            rbin_q <= '0;
            rgray_q <= '0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            rbin_q <= rbin_d;
            rgray_q <= rgray_d;
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
        end
    end
endmodule : ddrcap_fifo

//--- sim/ddrcap_ctrl_model.sv
// Memory controller model driving the command, address and write beat pins.
// Assumes a free running memory clock; every pin changes on its falling edge.
`timescale 1ns/1ns
module ddrcap_ctrl_model (
    input wire logic i_ck,
    output logic o_cke,
    output logic [3:0] o_cmd,
    output logic [2:0] o_ba,
    output logic [12:0] o_addr,
    output logic [35:0] o_beat
);
    initial begin
        o_cke = 1'b1;
        o_cmd = 4'hF;
        o_ba = 3'h0;
        o_addr = 13'h0000;
        o_beat = 36'h0;
    end
    // Idle lines toggle, so the device never profits from a stale value.
    task automatic issue(input logic [3:0] cmd, input logic [2:0] ba, input logic [12:0] a,
                         input logic cke, input int lat, input logic [35:0] b[$]);
        @(negedge i_ck);
        o_cmd = cmd;
        o_ba = ba;
        o_addr = a;
        o_cke = cke;
        for (int k = 1; k <= lat + b.size(); k++) begin
            @(negedge i_ck);
            o_cmd = 4'hF;
            o_addr = ~o_addr;
            o_ba = ~o_ba;
            o_beat = (k >= lat && k < lat + b.size()) ? b[k - lat] : ~o_beat;
        end
    endtask : issue
endmodule : ddrcap_ctrl_model

//--- sim/testbench.sv
// Self-checking bench: controller model on the memory pins, random sink on write records.
// Assumes CAS and write latency of 5 and a record FIFO of four words.
`timescale 1ns/1ns
module testbench;
    localparam int CL = 5;
    localparam int CWL = 5;
    logic core_clk = 1'b0;
    logic mem_ck = 1'b0;
    logic reset = 1'b1;
    logic bl8 = 1'b1;
    logic il = 1'b0;
    logic [1:0] al_c = 2'h0;
    logic rdy = 1'b0;
    logic hold = 1'b0;
    logic vld, pd, sr, ovf, oe, ard, cke;
    logic [7:0] opn;
    logic [3:0] cmd;
    logic [2:0] ba, abk;
    logic [12:0] addr, arow;
    logic [9:0] acol;
    logic [35:0] beat;
    logic [15:0] dqr, dqf;
    logic [12:0] rows [8];
    logic [31:0] rq [$];
    logic [35:0] bq [$];
    ddrcap_pkg::ddrcap_rec_t wr, wq [$];
    int fails = 0;
    int samples_checked = 0;
    always #4 core_clk = ~core_clk;
    initial begin
        #5;
        forever #16 mem_ck = ~mem_ck;
    end
    ddrcap_ctrl_model u_ddrcap_ctrl_model (.i_ck(mem_ck), .o_cke(cke), .o_cmd(cmd), .o_ba(ba), .o_addr(addr),
        .o_beat(beat));
    ddrcap_top #(.CAS_LAT(CL), .CWL(CWL), .FIFO_DEPTH(4)) u_ddrcap_top (.i_core_clk(core_clk), .i_reset(reset),
        .i_cfg_bl8(bl8), .i_cfg_interleave(il), .i_cfg_al(al_c), .i_wr_ready(rdy), .o_wr_valid(vld),
        .o_wr_bank(wr.bank), .o_wr_row(wr.row), .o_wr_col(wr.col), .o_wr_data(wr.data), .o_wr_be(wr.be),
        .o_powerdown(pd), .o_self_refresh(sr), .o_overflow(ovf), .o_bank_open(opn), .i_mem_ck(mem_ck),
        .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
        .i_addr(addr), .i_dq_rise(beat[15:0]), .i_dq_fall(beat[31:16]), .i_dm_rise(beat[33:32]),
        .i_dm_fall(beat[35:34]), .i_rd_word({3'h5, abk, arow, acol, 3'h2}), .o_dq_rise(dqr), .o_dq_fall(dqf),
        .o_dq_oe(oe), .o_arr_rd(ard), .o_arr_bank(abk), .o_arr_row(arow), .o_arr_col(acol));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic cmd1(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a, input logic k);
        logic [35:0] none [$];
        u_ddrcap_ctrl_model.issue(c, b, a, k, 1, none);
        repeat (4) @(negedge mem_ck);
    endtask : cmd1
    // Notes the expected pairs of one burst, issues it, and times the first read pair.
    task automatic burst(input logic rd, input logic [2:0] b, input logic [9:0] c, input logic ch, input logic ap);
        int al;
        int np;
        int n;
        logic [9:0] pc;
        al = (al_c == 2'h1) ? CL - 1 : (al_c == 2'h2) ? CL - 2 : 0;
        np = (bl8 && !ch) ? 4 : 2;
        bq = {};
        for (int k = 0; k < np; k++) begin
            pc = c;
            pc[2:0] = il ? c[2:0] ^ 3'(2 * k) : (np == 4) ? c[2:0] + 3'(2 * k) : {c[2], c[1:0] + 2'(2 * k)};
            if (rd)
                rq.push_back({3'h5, b, rows[b], pc, 3'h2});
            else begin
                bq.push_back({4'($urandom), 32'($urandom)});
                wq.push_back({b, rows[b], pc, bq[k][31:0], ~bq[k][35:32]});
            end
        end
        // The device takes the first write pair one edge after its write latency has run out.
        u_ddrcap_ctrl_model.issue({3'b010, rd}, b, {~ch, 1'b0, ap, c}, 1'b1, rd ? 1 : al + CWL + 1, bq);
        for (n = 0; rd && oe !== 1'b1 && n < 64; n++) @(negedge mem_ck);
        if (rd) chk(n, al + CL + 1);
        if (rd) chk(ard, 1'b1);
        for (n = 0; oe === 1'b1 && n < 64; n++) @(negedge mem_ck);
        if (rd) chk(n, np);
    endtask : burst
    always @(negedge core_clk) rdy <= !hold && ($urandom % 4 != 0);
    always @(negedge mem_ck)
        if (oe === 1'b1) chk({dqf, dqr}, rq.size() > 0 ? rq.pop_front() : 32'hFFFFFFFF);
    always @(posedge core_clk)
        if (vld === 1'b1 && rdy === 1'b1) chk(wr, wq.size() > 0 ? 64'(wq.pop_front()) : {64{1'b1}});
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
    initial begin
        logic [2:0] b;
        void'($urandom(5144));
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) reset = 1'b0;
        repeat (6) @(negedge mem_ck);
        for (int t = 0; t < 6; t++) begin
            @(negedge core_clk);
            al_c = 2'(t % 4);
            il = t[0];
            bl8 = t < 4;
            repeat (8) @(negedge mem_ck);
            b = 3'($urandom);
            rows[b] = 13'($urandom);
            rows[b ^ 3'h1] = 13'($urandom);
            cmd1(4'h3, b, rows[b], 1'b1);
            cmd1(4'h3, b ^ 3'h1, rows[b ^ 3'h1], 1'b1);
            burst(1'b1, b, 10'($urandom) & 10'h3FE, t[1], 1'b0);
            burst(1'b1, b ^ 3'h1, 10'($urandom) & 10'h3FE, 1'b0, 1'b1);
            burst(1'b0, b, 10'($urandom) & 10'h3FE, t[1], 1'b0);
            chk(opn, 8'h1 << b);
            cmd1(4'h3, b ^ 3'h1, rows[b ^ 3'h1], 1'b1);
            cmd1(4'hB, b ^ 3'h2, 13'h0000, 1'b1);
            cmd1(4'h2, b, {2'h0, t[0], 10'h000}, 1'b1);
            chk(opn, t[0] ? 8'h00 : 8'h1 << (b ^ 3'h1));
            cmd1(4'h2, b, 13'h0400, 1'b1);
            cmd1(4'h1, 3'h0, 13'h0000, 1'b1);
            $display("test %0d done", t);
        end
        for (int k = 0; wq.size() > 0 && k < 400; k++) @(negedge core_clk);
        chk(wq.size(), 0);
        cmd1(4'hF, 3'h0, 13'h0000, 1'b0);
        chk(pd, 1'b1);
        cmd1(4'hF, 3'h0, 13'h0000, 1'b1);
        chk(pd, 1'b0);
        cmd1(4'h1, 3'h0, 13'h0000, 1'b0);
        chk(sr, 1'b1);
        cmd1(4'hF, 3'h0, 13'h0000, 1'b1);
        // A stalled sink lets two full bursts overrun the record FIFO.
        hold = 1'b1;
        @(negedge core_clk) bl8 = 1'b1;
        cmd1(4'h3, 3'h0, rows[0], 1'b1);
        burst(1'b0, 3'h0, 10'h000, 1'b0, 1'b0);
        burst(1'b0, 3'h0, 10'h008, 1'b0, 1'b0);
        repeat (8) @(negedge mem_ck);
        chk(ovf, 1'b1);
        @(negedge core_clk) reset = 1'b1;
        repeat (16) @(negedge core_clk);
        chk({ovf, opn}, 9'h000);
        $display("test power and overflow done");
        give_verdict();
    end
endmodule : testbench
